/* vic_host.sv */
// vic_host: apb-programmed host that drives an eight-input vectored
// interrupt controller through its strobe pins and runs ack sequences
// assumes: device pins synchronous to clk; pad wires resolved outside
//
// What this block does
// - write and read strobes reach the device only while chip select is low; acknowledge goes with it high
// - a write strobe under chip select delivers a command byte
// - reg_select_line chooses which command or status register is used
// - otherwise host drives that pin: 1 master, 0 slave
// - edge mode: requester raises line and holds until acknowledged; the host never reads CTRL_EDGE_POS, request_inputs just follow OFF_REQ
// - host issues acknowledge pulses, collecting one vector byte each
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module vic_host #(
    parameter int NREQ = 8              // request lines driven
) (
    input  wire logic        clk,       // 125 MHz clock
    input  wire logic        arst_n,    // async reset, active low
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb enable
    input  wire logic        pwrite,    // apb direction
    input  wire logic [7:0]  paddr,     // apb byte address
    input  wire logic [31:0] pwdata,    // apb write data
    output logic [31:0]      prdata,    // apb read data
    output logic             pready,    // apb ready
    output logic             pslverr,   // apb error
    output logic             irq,       // level interrupt
    output logic             cs_n,      // device chip select
    output logic             wr_n,      // device write strobe
    output logic             rd_n,      // device read strobe
    output logic             ack_n,     // irq_acknowledge strobe
    output logic             a0,        // reg_select_line
    output logic [7:0]       d_out,     // data bus out
    output logic             d_oe,      // data bus drive enable
    input  wire logic [7:0]  d_in,      // data bus in
    input  wire logic        dev_int,   // device interrupt output
    output logic [NREQ-1:0]  request_inputs,  // request lines
    output logic             sel_out,   // slave_sel_or_buf_enable out
    output logic             sel_oe,    // slave_sel_or_buf_enable drive
    input  wire logic        sel_in,    // slave_sel_or_buf_enable in
    input  wire logic [2:0]  cascade_id_lines // observed cascade id
);
    typedef enum {H_IDLE, H_WAIT, H_ACK} vic_host_state_t;
    typedef struct packed {
        vic_host_state_t st;
        logic [31:0] ctrl;
        logic [7:0]  rdata;
        logic [23:0] vec;
        logic [2:0]  cas;
        logic [1:0]  nack;
        logic [2:0]  ev;
        logic [2:0]  msk;
        logic [NREQ-1:0] req;
        logic        int_q;
        logic        start;
        logic [1:0]  kind;
        logic        sa0;
        logic [7:0]  wbyte;
    } vic_host_st_t;
    vic_host_st_t s_q, s_d;
    vic_pins_if pif ();
    logic wr_acc, rd_acc, slv_err;
    logic [2:0] ev_set;
    logic [31:0] rd_val;
    vic_pin_seq u_seq (
        .clk(clk), .arst_n(arst_n), .p(pif),
        .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .ack_n(ack_n), .a0(a0),
        .d_out(d_out), .d_oe(d_oe), .d_in(d_in));
    // every access answers in its first access cycle
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign slv_err = paddr[1:0] != 2'b00 || paddr > vic_pkg::OFF_REQ;
    // read mux, zero for unmapped; status bit4 shows the level on
    // slave_sel_or_buf_enable so software can see who owns that pin
    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            vic_pkg::OFF_CTRL:   rd_val = s_q.ctrl;
            vic_pkg::OFF_STATUS: rd_val = {27'h000_0000, sel_in, s_q.int_q,
                                  pif.busy || s_q.st != H_IDLE, 2'b00};
            vic_pkg::OFF_RDATA:  rd_val = {24'h00_0000, s_q.rdata};
            vic_pkg::OFF_VEC:    rd_val = {5'h00, s_q.cas, s_q.vec};
            vic_pkg::OFF_IRQ_ST: rd_val = {29'h0000_0000, s_q.ev};
            vic_pkg::OFF_IRQ_MK: rd_val = {29'h0000_0000, s_q.msk};
            vic_pkg::OFF_REQ:    rd_val = 32'(s_q.req);
            default:             rd_val = 32'h0000_0000;
        endcase
    end
    // command engine, event capture and register writes
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        ev_set = 3'b000;
        // device interrupt seen rising; inputs already synchronous
        s_d.int_q = dev_int;
        if (dev_int && !s_q.int_q) ev_set[vic_pkg::EV_DEV_INT] = 1'b1;
        case (s_q.st)
            H_IDLE: if (wr_acc && paddr == vic_pkg::OFF_CMD) begin
                s_d.start = 1'b1;
                s_d.kind = pwdata[vic_pkg::CMD_WR_POS] ? 2'd0 : 2'd1;
                s_d.sa0 = pwdata[vic_pkg::CMD_ADDR_POS];
                s_d.wbyte = pwdata[7:0];
                s_d.st = H_WAIT;
            end else if (wr_acc && paddr == vic_pkg::OFF_VEC) begin
                // three acknowledge pulses, one byte each
                s_d.start = 1'b1;
                s_d.kind = 2'd2;
                s_d.nack = 2'd0;
                s_d.vec = 24'h00_0000;
                s_d.cas = cascade_id_lines;
                s_d.st = H_ACK;
            end
            H_WAIT: if (pif.done) begin
                if (s_q.kind == 2'd1) s_d.rdata = pif.rdata;
                ev_set[vic_pkg::EV_CMD_DONE] = 1'b1;
                s_d.st = H_IDLE;
            end
            H_ACK: if (pif.done) begin
                // opcode first, then low and high vector bytes
                s_d.vec = {pif.rdata, s_q.vec[23:8]};
                if (s_q.nack == 2'(vic_pkg::ACK_PULSES - 1)) begin
                    ev_set[vic_pkg::EV_ACK_DONE] = 1'b1;
                    s_d.st = H_IDLE;
                end else begin
                    s_d.nack = s_q.nack + 2'd1;
                    s_d.start = 1'b1;
                end
            end
            default: s_d.st = H_IDLE;
        endcase
        if (wr_acc && paddr == vic_pkg::OFF_CTRL) s_d.ctrl = pwdata;
        if (wr_acc && paddr == vic_pkg::OFF_IRQ_MK) s_d.msk = pwdata[2:0];
        if (wr_acc && paddr == vic_pkg::OFF_REQ)
            s_d.req = pwdata[NREQ-1:0];
        // read clears, a new event in the same cycle wins
        if (rd_acc && paddr == vic_pkg::OFF_IRQ_ST) s_d.ev = ev_set;
        else s_d.ev = s_q.ev | ev_set;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{st: H_IDLE, ctrl: vic_pkg::CTRL_RESET, rdata: 8'h00,
                     vec: 24'h00_0000, cas: 3'b000, nack: 2'd0,
                     ev: 3'b000, msk: 3'b000, req: '0, int_q: 1'b0,
                     start: 1'b0, kind: 2'd0, sa0: 1'b0, wbyte: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end
    assign pif.start = s_q.start;
    assign pif.kind = s_q.kind;
    assign pif.a0 = s_q.sa0;
    assign pif.wdata = s_q.wbyte;
    assign prdata = rd_acc ? rd_val : 32'h0000_0000;
    assign pready = 1'b1;
    assign pslverr = psel && penable && slv_err;
    assign irq = |(s_q.ev & s_q.msk);
    assign request_inputs = s_q.req;
    // buffered mode leaves the pin to the device
    assign sel_oe = !s_q.ctrl[vic_pkg::CTRL_BUFMODE_POS];
    assign sel_out = s_q.ctrl[vic_pkg::CTRL_MASTER_POS];
endmodule : vic_host
`default_nettype wire

/* vic_pkg.sv */
// vic_pkg: constants for the host-side driver of a vectored irq controller
// assumes: 125 MHz clk, apb slave registers word aligned, 8-bit device bus
package vic_pkg;
    // apb register offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CMD    = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_RDATA  = 8'h0C;
    localparam logic [7:0] OFF_VEC    = 8'h10;
    localparam logic [7:0] OFF_IRQ_ST = 8'h14;
    localparam logic [7:0] OFF_IRQ_MK = 8'h18;
    localparam logic [7:0] OFF_REQ    = 8'h1C;
    // ctrl fields
    localparam int CTRL_MASTER_POS = 0;
    localparam int CTRL_BUFMODE_POS = 1;
    localparam int CTRL_EDGE_POS = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // cmd fields: [7:0] data, [8] reg_select_line, [9] write(1)/read(0)
    localparam int CMD_ADDR_POS = 8;
    localparam int CMD_WR_POS   = 9;
    // status/irq event bits
    localparam int EV_CMD_DONE = 0;
    localparam int EV_ACK_DONE = 1;
    localparam int EV_DEV_INT  = 2;
    // device bus timing
    localparam int STROBE_NS   = 80;
    localparam int CLK_NS      = 8;
    localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACK_PULSES  = 3;
    localparam logic [7:0] CALL_OPCODE = 8'b1100_1101;
endpackage : vic_pkg

/* vic_pins_if.sv */
// vic_pins_if: strobe request/answer between host core and pin sequencer
// assumes: one clock; the core starts one cycle at a time
`timescale 1ns/10ps
`default_nettype none
interface vic_pins_if;
    logic       start;   // one-cycle request
    logic [1:0] kind;    // 0 write, 1 read, 2 acknowledge
    logic       a0;      // address line value
    logic [7:0] wdata;   // write byte
    logic       busy;    // sequencer busy
    logic       done;    // one-cycle done pulse
    logic [7:0] rdata;   // byte captured at end of strobe
    modport core (output start, kind, a0, wdata, input busy, done, rdata);
    modport seq  (input start, kind, a0, wdata, output busy, done, rdata);
endinterface : vic_pins_if
`default_nettype wire

/* vic_tick.sv */
// vic_tick: counts strobe width as clock cycles, pulses when elapsed
// assumes: restart is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module vic_tick #(
    parameter int CYC = 10
) (
    input  wire logic clk,     // clock
    input  wire logic arst_n,  // async reset
    input  wire logic restart, // begin counting
    output logic      expired  // one-cycle pulse at end
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        run;
    } vic_tick_st_t;
    vic_tick_st_t s_q, s_d;
    // count down from the restart
    always_comb begin
        s_d = s_q;
        expired = 1'b0;
        if (restart) begin
            s_d.cnt = 16'(CYC - 1);
            s_d.run = 1'b1;
        end else if (s_q.run) begin
            if (s_q.cnt == 16'h0000) begin
                s_d.run = 1'b0;
                expired = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 16'h0001;
            end
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : vic_tick
`default_nettype wire

/* vic_pin_seq.sv */
// vic_pin_seq: drives one strobe on the device pins with setup and hold
// assumes: device is clockless; data sampled at the end of the strobe
`timescale 1ns/10ps
`default_nettype none
module vic_pin_seq (
    input  wire logic clk,          // clock
    input  wire logic arst_n,       // async reset
    vic_pins_if.seq   p,            // request from the core
    output logic      cs_n,         // chip select
    output logic      wr_n,         // write strobe
    output logic      rd_n,         // read strobe
    output logic      ack_n,        // irq_acknowledge strobe
    output logic      a0,           // reg_select_line
    output logic [7:0] d_out,       // data bus out
    output logic      d_oe,         // data bus drive enable
    input  wire logic [7:0] d_in    // data bus in
);
    typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD} vic_seq_state_t;
    typedef struct packed {
        vic_seq_state_t st;
        logic [1:0] kind;
        logic       cs_n, wr_n, rd_n, ack_n, a0, oe;
        logic [7:0] dout, rdata;
        logic       done;
    } vic_seq_st_t;
    vic_seq_st_t s_q, s_d;
    logic tick_go, tick_end;
    vic_tick #(.CYC(vic_pkg::STROBE_CYC)) u_tick (
        .clk(clk), .arst_n(arst_n), .restart(tick_go), .expired(tick_end));
    // setup a cycle, strobe low for the width, release, hold a cycle
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        tick_go = 1'b0;
        case (s_q.st)
            S_IDLE: if (p.start) begin
                s_d.kind = p.kind;
                s_d.a0 = p.a0;
                s_d.dout = p.wdata;
                // acknowledge needs no chip select
                s_d.cs_n = (p.kind == 2'd2);
                s_d.oe = (p.kind == 2'd0);
                s_d.st = S_SETUP;
            end
            S_SETUP: begin
                s_d.wr_n = !(s_q.kind == 2'd0);
                s_d.rd_n = !(s_q.kind == 2'd1);
                s_d.ack_n = !(s_q.kind == 2'd2);
                tick_go = 1'b1;
                s_d.st = S_STROBE;
            end
            S_STROBE: if (tick_end) begin
                s_d.rdata = d_in;
                s_d.wr_n = 1'b1;
                s_d.rd_n = 1'b1;
                s_d.ack_n = 1'b1;
                s_d.st = S_HOLD;
            end
            S_HOLD: begin
                s_d.cs_n = 1'b1;
                s_d.oe = 1'b0;
                s_d.done = 1'b1;
                s_d.st = S_IDLE;
            end
            default: s_d.st = S_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{st: S_IDLE, kind: 2'd0, cs_n: 1'b1, wr_n: 1'b1,
                     rd_n: 1'b1, ack_n: 1'b1, a0: 1'b0, oe: 1'b0,
                     dout: 8'h00, rdata: 8'h00, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
    assign cs_n = s_q.cs_n;
    assign wr_n = s_q.wr_n;
    assign rd_n = s_q.rd_n;
    assign ack_n = s_q.ack_n;
    assign a0 = s_q.a0;
    assign d_out = s_q.dout;
    assign d_oe = s_q.oe;
    assign p.busy = (s_q.st != S_IDLE);
    assign p.done = s_q.done;
    assign p.rdata = s_q.rdata;
endmodule : vic_pin_seq
`default_nettype wire

/* vic_chk.sv */
// vic_chk: port-level assertions for the vic_host controller
// assumes: bound onto vic_host; single clk domain, async arst_n
`timescale 1ns/10ps
`default_nettype none
module vic_chk (
    input wire logic        clk,     // clock
    input wire logic        arst_n,  // async reset
    input wire logic        psel,    // apb select
    input wire logic        penable, // apb enable
    input wire logic        pwrite,  // apb direction
    input wire logic [7:0]  paddr,   // apb address
    input wire logic [31:0] prdata,  // apb read data
    input wire logic        pready,  // apb ready
    input wire logic        pslverr, // apb error
    input wire logic        cs_n,    // chip select
    input wire logic        wr_n,    // write strobe
    input wire logic        rd_n,    // read strobe
    input wire logic        ack_n,   // acknowledge strobe
    input wire logic        a0,      // reg_select_line
    input wire logic [7:0]  d_out,   // data out
    input wire logic        d_oe     // data drive enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // access phase of an apb transfer
    wire logic acc = psel && penable;
    a_strobe_cs: assert property ((!wr_n || !rd_n) |-> !cs_n)
        else $error("strobe without chip select");
    a_cs_release: assert property (($rose(wr_n) || $rose(rd_n))
        |-> !cs_n ##1 cs_n)
        else $error("chip select not released after strobe");
    a_ack_unselected: assert property (!ack_n |-> cs_n && wr_n && rd_n)
        else $error("acknowledge mixed with selected strobes");
    a_write_stable: assert property (!wr_n
        |-> d_oe && $stable(d_out) && $stable(a0))
        else $error("write byte or select line moved under strobe");
    a_bus_released: assert property ((!rd_n || !ack_n) |-> !d_oe)
        else $error("host drives bus while device answers");
    a_ack_width: assert property ($fell(ack_n)
        |-> !ack_n [*8] ##[3:5] ack_n)
        else $error("acknowledge pulse width wrong");
    a_zero_wait: assert property (acc |-> pready)
        else $error("apb answer delayed");
    a_bad_offset: assert property (acc
        && (paddr > 8'h1C || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not refused");
    a_err_idle: assert property (!acc |-> !pslverr)
        else $error("error flag outside access phase");
    a_rdata_idle: assert property (!(acc && !pwrite)
        |-> prdata == 32'h0000_0000)
        else $error("read data outside read access");
    c_ack: cover property ($fell(ack_n));
    c_write: cover property ($fell(wr_n));
    c_read: cover property ($fell(rd_n));
    c_err: cover property (acc && pslverr);
endmodule : vic_chk
bind vic_host vic_chk i_vic_chk (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .ack_n(ack_n), .a0(a0), .d_out(d_out), .d_oe(d_oe));
`default_nettype wire

/* vic_dev.sv */
// vic_dev: behavioural clockless interrupt controller on the strobe pins
// assumes: level-triggered, single master, 8-bit call mode, no auto eoi
`timescale 1ns/10ps
`default_nettype none
module vic_dev #(
    parameter logic [2:0] CAS_ID = 3'h5,  // arbitrary cascade id
    parameter logic [7:0] VEC_HI = 8'h3C, // arbitrary high vector byte
    parameter logic [7:0] VEC_LO = 8'h80  // low vector base, level in [2:0]
) (
    input  wire logic       cs_n,    // chip select
    input  wire logic       wr_n,    // write strobe
    input  wire logic       rd_n,    // read strobe
    input  wire logic       ack_n,   // acknowledge strobe
    input  wire logic       a0,      // reg_select_line
    input  wire logic [7:0] d,       // data bus level
    input  wire logic [7:0] req,     // request_inputs
    input  wire logic       sp,      // slave_sel_or_buf_enable level
    output logic [7:0]      q,       // byte driven
    output logic            q_oe,    // drives data bus
    output logic            dev_int, // interrupt to host
    output logic [2:0]      cas      // cascade_id_lines
);
    logic [7:0] in_service_bits = 8'h00; // in_service_bits
    logic [7:0] request_mask_bits = 8'h00; // request_mask_bits
    logic [1:0] ph  = 2'd2;  // pulse number, 2 so first pulse is 0
    logic [2:0] lvl = 3'd0;
    logic [3:0] t;
    // highest priority is line 0; {found, line}
    function automatic logic [3:0] top(input logic [7:0] v);
        top = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) top = {1'b1, 3'(i)};
        end
    endfunction : top
    // only strictly higher levels than the one in service interrupt
    wire logic [3:0] p = top(req & ~request_mask_bits);
    wire logic [3:0] s = top(in_service_bits);
    assign dev_int = p[3] && (!s[3] || p[2:0] < s[2:0]);
    // command capture at the end of a selected write; x at time 0 ignored
    always @(posedge wr_n) begin
        if (!cs_n && a0) request_mask_bits = d;
        else if (!cs_n && d == 8'h20) in_service_bits = in_service_bits & (in_service_bits - 8'h01);
    end
    // acknowledge works with chip select high; first pulse takes a level
    always @(negedge ack_n) begin
        ph = (ph == 2'd2) ? 2'd0 : ph + 2'd1;
        if (ph == 2'd0) begin
            t = top(req & ~request_mask_bits);
            lvl = t[2:0];
            in_service_bits[lvl] = 1'b1;
        end
    end
    assign q_oe = (!cs_n && !rd_n) || !ack_n;
    assign q = !ack_n ? (ph == 2'd0 ? vic_pkg::CALL_OPCODE :
               ph == 2'd1 ? (VEC_LO | 8'(lvl)) : VEC_HI) :
               (a0 ? request_mask_bits : req);
    // slave lines are inputs; with no other master a pull-down is assumed
    assign cas = sp ? CAS_ID : 3'h0;
endmodule : vic_dev
`default_nettype wire

/* tb.sv */
// tb: apb-driven bench for vic_host against the behavioural device
// assumes: zero-wait apb slave; event waits go through the irq output
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, bus_q = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, r;
    logic        e;
    wire logic [31:0] prdata;
    wire logic [7:0]  d_out, m_q, req, bus;
    wire logic [2:0]  cas;
    wire logic pready, pslverr, irq, cs_n, wr_n, rd_n, ack_n, a0, d_oe;
    wire logic m_oe, dev_int, sel_out, sel_oe, sel_in;
    int bad_count = 0, checks_done = 0;
    initial forever #4 clk = ~clk;
    // released bus shows the inverse of its last level; sel pin pulled up
    assign bus = d_oe ? d_out : (m_oe ? m_q : ~bus_q);
    assign sel_in = sel_oe ? sel_out : 1'b1;
    always @(posedge clk) bus_q <= bus;
    vic_host i_vic_host (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .ack_n(ack_n), .a0(a0),
        .d_out(d_out), .d_oe(d_oe), .d_in(bus), .dev_int(dev_int),
        .request_inputs(req), .sel_out(sel_out), .sel_oe(sel_oe),
        .sel_in(sel_in), .cascade_id_lines(cas));
    vic_dev i_vic_dev (.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .ack_n(ack_n),
        .a0(a0), .d(bus), .req(req), .sp(sel_in), .q(m_q), .q_oe(m_oe),
        .dev_int(dev_int), .cas(cas));
    task automatic give_verdict();
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; an idle edge first keeps each strobe change single
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            bad_count++;
            give_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // unmask one event, wait for irq, clear it by reading, see irq fall
    task automatic wait_irq(input logic [2:0] m);
        int n;
        apb(1'b1, vic_pkg::OFF_IRQ_MK, 32'(m));
        for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge clk);
        if (n == 400) begin
            bad_count++;
            give_verdict();
        end
        apb(1'b0, vic_pkg::OFF_IRQ_ST, 32'h0000_0000);
        chk(r[2:0] & m, m);
        @(posedge clk);
        chk(irq, 1'b0);
    endtask : wait_irq
    // device command: {write, a0, byte}, then read back captured byte
    task automatic dev_cmd(input logic [31:0] c);
        apb(1'b1, vic_pkg::OFF_CMD, c);
        wait_irq(3'h1);
        apb(1'b0, vic_pkg::OFF_RDATA, 32'h0000_0000);
    endtask : dev_cmd
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        chk({sel_oe, sel_out, cs_n, ack_n}, 4'hF);
        apb(1'b0, vic_pkg::OFF_CTRL, 32'h0000_0000);
        chk(r, vic_pkg::CTRL_RESET);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(e, 1'b1);
        dev_cmd(32'h0000_0304);
        chk(i_vic_dev.request_mask_bits, 8'h04);
        apb(1'b1, vic_pkg::OFF_REQ, 32'h0000_000C);
        repeat (4) @(posedge clk);
        chk(irq, 1'b0);
        wait_irq(3'h4);
        apb(1'b0, vic_pkg::OFF_STATUS, 32'h0000_0000);
        chk(r[3], 1'b1);
        dev_cmd(32'h0000_0000);
        chk(r[7:0], 8'h0C);
        dev_cmd(32'h0000_0100);
        chk(r[7:0], 8'h04);
        apb(1'b1, vic_pkg::OFF_VEC, 32'h0000_0000);
        wait_irq(3'h2);
        apb(1'b0, vic_pkg::OFF_VEC, 32'h0000_0000);
        chk(r, {5'h00, 3'h5, 8'h3C, 8'h83, vic_pkg::CALL_OPCODE});
        apb(1'b0, vic_pkg::OFF_STATUS, 32'h0000_0000);
        chk(r[3], 1'b0);
        dev_cmd(32'h0000_0220);
        apb(1'b0, vic_pkg::OFF_STATUS, 32'h0000_0000);
        chk(r[3], 1'b1);
        // an acknowledge order while a command runs must be refused
        apb(1'b1, vic_pkg::OFF_CMD, 32'h0000_0304);
        apb(1'b0, vic_pkg::OFF_STATUS, 32'h0000_0000);
        chk(r[2], 1'b1);
        apb(1'b1, vic_pkg::OFF_VEC, 32'h0000_0000);
        wait_irq(3'h1);
        apb(1'b0, vic_pkg::OFF_STATUS, 32'h0000_0000);
        chk(r[3:2], 2'b10);
        apb(1'b1, vic_pkg::OFF_CTRL, 32'h0000_0003);
        repeat (2) @(posedge clk);
        chk(sel_oe, 1'b0);
        apb(1'b0, vic_pkg::OFF_STATUS, 32'h0000_0000);
        chk(r[4], 1'b1);
        apb(1'b1, vic_pkg::OFF_CTRL, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk({sel_oe, sel_out}, 2'b10);
        apb(1'b0, vic_pkg::OFF_STATUS, 32'h0000_0000);
        chk(r[4], 1'b0);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
